// file: hw/cle_instr_exec.sv
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module cle_instr_exec #(
  parameter int unsigned OSC_DIV = 4,
  parameter int unsigned BLINK_DIV = cle_pkg::BLINK_DIV_DFLT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire cle_pkg::cle_avs_req_t avs,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic lcd_drive_en,
  output logic bias_gen_en,
  output logic cursor_underline_en,
  output logic cursor_blink_en,
  output logic blink_phase,
  output logic [5:0] display_shift_pos,
  output logic [1:0] mux_select
);

  localparam logic [15:0] OSC_LAST = 16'(OSC_DIV - 1);
  localparam logic [15:0] BLINK_HALF = 16'(BLINK_DIV / 2 - 1);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Text RAM steps wrap 4Fh to 00h, going 27h to 40h in two-line mode; glyph RAM wraps over 7 bits
  function automatic logic [6:0] step_ptr(input logic [6:0] p,
      input logic up, input logic two, input logic glyph);
    logic [6:0] r;
    r = up ? 7'(p + 7'h01) : 7'(p - 7'h01);
    if (!glyph) begin
      if (up && p == cle_pkg::LAST_L2) r = 7'h00;
      if (!up && p == 7'h00) r = cle_pkg::LAST_L2;
      if (two && up && p == cle_pkg::LAST_L1) r = cle_pkg::LINE2_BASE;
      if (two && !up && p == cle_pkg::LINE2_BASE) r = cle_pkg::LAST_L1;
    end
    return r;
  endfunction : step_ptr

  // Display offset counts left shifts modulo the 40-column line
  function automatic logic [5:0] shift_pos(input logic [5:0] s,
      input logic left);
    logic [5:0] r;
    if (left) r = (s == cle_pkg::SHIFT_LAST) ? 6'h00 : 6'(s + 6'h01);
    else r = (s == 6'h00) ? cle_pkg::SHIFT_LAST : 6'(s - 6'h01);
    return r;
  endfunction : shift_pos

  // ************************************************************
  // State
  // ************************************************************
  cle_pkg::cle_mode_t mode_reg, mode_next;
  cle_pkg::cle_ext_t ext_reg, ext_next;
  cle_pkg::cle_state_t state_reg;
  logic [6:0] ram_pointer_reg, ptr_next;
  logic [5:0] disp_shift_reg, shift_next;
  logic glyph_sel_reg, glyph_next;
  logic [7:0] data_holding_register, hold_next;
  logic serial_link_reg;
  logic wait_reg;
  logic nib_phase_reg;
  logic [3:0] nib_hi_reg;
  logic [15:0] osc_cnt_reg;
  logic [15:0] blink_cnt_reg;
  logic [7:0] tick_cnt_reg;
  logic [7:0] limit_reg;
  logic [7:0] fill_idx_reg;
  logic [31:0] readdata_reg;
  logic lcd_reg, bias_reg, under_reg, blinken_reg, phase_reg;
  logic [1:0] mux_reg;
  logic [7:0] text_ram [128];
  logic [4:0] glyph_ram [128];

  // ************************************************************
  // Avalon decode and nibble pairing
  // ************************************************************
  // One wait state: a request is answered on the second edge
  wire req = avs.read | avs.write;
  wire ack = req & ~wait_reg;
  wire wr_ack = ack & avs.write & avs.byteenable[0];
  wire rd_ack = ack & avs.read;
  wire sel_instr = avs.address == cle_pkg::OFF_INSTR;
  wire sel_data = avs.address == cle_pkg::OFF_DATA;
  wire sel_status = avs.address == cle_pkg::OFF_STATUS;
  wire sel_config = avs.address == cle_pkg::OFF_CONFIG;
  wire sel_modes = avs.address == cle_pkg::OFF_MODES;
  wire sel_ext = avs.address == cle_pkg::OFF_EXT;
  wire bus8 = mode_reg.bus_width_select;
  wire instruction_pending_flag = state_reg == cle_pkg::CLE_EXEC;
  wire byte_wr = wr_ack & (sel_instr | sel_data);
  wire byte_rd = rd_ack & (sel_status | sel_data);
  wire wr_done = byte_wr & (bus8 | nib_phase_reg);
  wire rd_done = byte_rd & (bus8 | nib_phase_reg);
  wire [7:0] ib = bus8 ? avs.writedata[7:0]
                       : {nib_hi_reg, avs.writedata[7:4]};

  // Busy drops instruction and data traffic without execution
  wire go = wr_done & ~instruction_pending_flag;
  wire go_i = go & sel_instr;
  wire go_w = go & sel_data;
  wire rd_go = rd_done & sel_data & ~instruction_pending_flag;
  wire start = go | rd_go;

  // ************************************************************
  // Instruction decode, basic and extended sets
  // ************************************************************
  wire h = mode_reg.ext_set;
  wire d_clear = ~h & (ib == 8'h01);
  wire d_home = ~h & (ib[7:1] == 7'h01);
  wire d_entry = ~h & (ib[7:2] == 6'h01);
  wire d_dctl = ~h & (ib[7:3] == 5'h01);
  wire d_shift = ~h & (ib[7:4] == 4'h1);
  wire d_gaddr = ~h & (ib[7:6] == 2'h1);
  wire d_taddr = ~h & ib[7];
  wire d_fset = ib[7:5] == 3'h1;
  wire d_scr = h & (ib[7:1] == 7'h01);
  wire d_dcfg = h & (ib[7:2] == 6'h01);
  wire d_icon = h & (ib[7:3] == 5'h01);
  wire d_temp = h & (ib[7:2] == 6'h04);
  wire d_hv = h & (ib[7:2] == 6'h10);
  wire d_vlcd = h & ib[7];
  wire [6:0] ptr_step = step_ptr(ram_pointer_reg, mode_reg.inc,
                                 mode_reg.two_line, glyph_sel_reg);
  wire [6:0] ptr_cur = step_ptr(ram_pointer_reg, ib[2],
                                mode_reg.two_line, glyph_sel_reg);
  wire [7:0] ram_at_step = glyph_sel_reg ? {3'h0, glyph_ram[ptr_step]}
                                         : text_ram[ptr_step];
  wire tick = osc_cnt_reg == OSC_LAST;
  wire filling = ~fill_idx_reg[7];

  // ************************************************************
  // Read mux
  // ************************************************************
  wire [7:0] byte_src = sel_status ? {instruction_pending_flag,
                                      ram_pointer_reg}
                                   : data_holding_register;
  wire [7:0] nib_out = nib_phase_reg ? {byte_src[3:0], 4'h0}
                                     : {byte_src[7:4], 4'h0};
  wire [31:0] rd_mux =
    (sel_status | sel_data) ? {24'h0, bus8 ? byte_src : nib_out} :
    sel_config ? {31'h0, serial_link_reg} :
    sel_modes ? {16'h0, disp_shift_reg, glyph_sel_reg, mode_reg} :
    sel_ext ? {10'h0, ext_reg} : 32'h0;

  // ************************************************************
  // Next-state of the programming model
  // ************************************************************
  always_comb begin
    mode_next = mode_reg;
    ext_next = ext_reg;
    ptr_next = ram_pointer_reg;
    shift_next = disp_shift_reg;
    glyph_next = glyph_sel_reg;
    hold_next = data_holding_register;
    if (go_i) begin
      if (d_clear) begin
        ptr_next = 7'h00;
        shift_next = 6'h00;
        glyph_next = 1'b0;
        mode_next.inc = 1'b1;
      end
      if (d_home) begin
        ptr_next = 7'h00;
        shift_next = 6'h00;
        glyph_next = 1'b0;
      end
      if (d_entry) begin
        mode_next.inc = ib[1];
        mode_next.autoshift = ib[0];
      end
      if (d_dctl) begin
        mode_next.disp_on = ib[2];
        mode_next.cursor_on = ib[1];
        mode_next.blink_on = ib[0];
      end
      // Display shift leaves the pointer; cursor shift steps it
      if (d_shift) begin
        if (ib[3]) shift_next = shift_pos(disp_shift_reg, ~ib[2]);
        else ptr_next = ptr_cur;
      end
      // Floating low lines make a first 4-bit set force these high
      if (d_fset) begin
        mode_next.bus_width_select = serial_link_reg | ib[4];
        mode_next.two_line = ib[2];
        mode_next.single_line_mux9 = ib[1];
        mode_next.ext_set = ib[0];
      end
      if (d_gaddr) begin
        ptr_next[5:0] = ib[5:0];
        glyph_next = 1'b1;
        hold_next = {3'h0, glyph_ram[{ram_pointer_reg[6], ib[5:0]}]};
      end
      if (d_taddr) begin
        ptr_next = ib[6:0];
        glyph_next = 1'b0;
        hold_next = text_ram[ib[6:0]];
      end
      if (d_scr) ext_next.scr_mirror = ib[0];
      if (d_dcfg) begin
        ext_next.col_mirror = ib[1];
        ext_next.row_mirror = ib[0];
      end
      if (d_icon) begin
        ext_next.icon_only_mode = ib[2];
        ext_next.icon_blink = ib[1];
        ext_next.direct_supply_mode = ib[0];
      end
      if (d_temp) ext_next.temp_coef = ib[1:0];
      if (d_hv) ext_next.hv_stages = ib[1:0];
      if (d_vlcd && !ib[6]) ext_next.vlcd_a = ib[5:0];
      if (d_vlcd && ib[6]) ext_next.vlcd_b = ib[5:0];
    end
    if (go_w) begin
      ptr_next = ptr_step;
      if (!glyph_sel_reg && mode_reg.autoshift)
        shift_next = shift_pos(disp_shift_reg, mode_reg.inc);
    end
    if (rd_go) begin
      ptr_next = ptr_step;
      hold_next = ram_at_step;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_reg <= cle_pkg::MODE_RST;
      ext_reg <= cle_pkg::EXT_RST;
      ram_pointer_reg <= 7'h00;
      disp_shift_reg <= 6'h00;
      glyph_sel_reg <= 1'b0;
      data_holding_register <= 8'h00;
    end else begin
      mode_reg <= mode_next;
      ext_reg <= ext_next;
      ram_pointer_reg <= ptr_next;
      disp_shift_reg <= shift_next;
      glyph_sel_reg <= glyph_next;
      data_holding_register <= hold_next;
    end
  end

  // Bus slave; readdata is taken as waitrequest drops, so it stands
  // at the edge where the master samples waitrequest low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      readdata_reg <= 32'h0;
      serial_link_reg <= 1'b0;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (avs.read && wait_reg) readdata_reg <= rd_mux;
      if (wr_ack && sel_config) serial_link_reg <= avs.writedata[0];
    end
  end

  // Nibble pairing, high half first; function set realigns it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nib_phase_reg <= 1'b0;
      nib_hi_reg <= 4'h0;
    end else begin
      if (go_i && d_fset) nib_phase_reg <= 1'b0;
      else if (!bus8 && (byte_wr || byte_rd))
        nib_phase_reg <= ~nib_phase_reg;
      if (byte_wr && !nib_phase_reg) nib_hi_reg <= avs.writedata[7:4];
    end
  end

  // Execution timer; reset runs a full clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= cle_pkg::CLE_EXEC;
      tick_cnt_reg <= 8'h00;
      limit_reg <= cle_pkg::TICKS_CLEAR;
      fill_idx_reg <= 8'h00;
    end else begin
      if (start) begin
        state_reg <= cle_pkg::CLE_EXEC;
        tick_cnt_reg <= 8'h00;
        limit_reg <= (go_i && d_clear) ? cle_pkg::TICKS_CLEAR
                                        : cle_pkg::TICKS_STD;
      end else if (instruction_pending_flag && tick) begin
        if (tick_cnt_reg == 8'(limit_reg - 8'h01))
          state_reg <= cle_pkg::CLE_IDLE;
        tick_cnt_reg <= 8'(tick_cnt_reg + 8'h01);
      end
      if (go_i && d_clear) fill_idx_reg <= 8'h00;
      else if (filling) fill_idx_reg <= 8'(fill_idx_reg + 8'h01);
    end
  end

  // RAM writes; fill and data writes never meet since busy blocks
  always_ff @(posedge clk) begin
    if (filling) text_ram[fill_idx_reg[6:0]] <= cle_pkg::BLANK_CODE;
    else if (go_w && !glyph_sel_reg) text_ram[ram_pointer_reg] <= ib;
    if (go_w && glyph_sel_reg) glyph_ram[ram_pointer_reg] <= ib[4:0];
  end

  // Oscillator tick divider and blink half-period counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_cnt_reg <= 16'h0000;
      blink_cnt_reg <= 16'h0000;
      phase_reg <= 1'b0;
    end else begin
      osc_cnt_reg <= tick ? 16'h0000 : 16'(osc_cnt_reg + 16'h0001);
      if (tick) begin
        if (blink_cnt_reg == BLINK_HALF) begin
          blink_cnt_reg <= 16'h0000;
          phase_reg <= ~phase_reg;
        end else begin
          blink_cnt_reg <= 16'(blink_cnt_reg + 16'h0001);
        end
      end
    end
  end

  // Display drive outputs, one cycle behind the mode bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lcd_reg <= 1'b0;
      bias_reg <= 1'b0;
      under_reg <= 1'b0;
      blinken_reg <= 1'b0;
      mux_reg <= cle_pkg::MUX_1X24;
    end else begin
      lcd_reg <= mode_reg.disp_on;
      bias_reg <= mode_reg.disp_on;
      under_reg <= mode_reg.disp_on & mode_reg.cursor_on
                   & ~glyph_sel_reg;
      blinken_reg <= mode_reg.disp_on & mode_reg.blink_on
                     & ~glyph_sel_reg;
      mux_reg <= mode_reg.single_line_mux9 ? cle_pkg::MUX_9 :
                 mode_reg.two_line ? cle_pkg::MUX_2X12
                                   : cle_pkg::MUX_1X24;
    end
  end

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = wait_reg;
  assign lcd_drive_en = lcd_reg;
  assign bias_gen_en = bias_reg;
  assign cursor_underline_en = under_reg;
  assign cursor_blink_en = blinken_reg;
  assign blink_phase = phase_reg;
  assign display_shift_pos = disp_shift_reg;
  assign mux_select = mux_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_clear_timer: assert property (go_i && d_clear |=>
      instruction_pending_flag && limit_reg == cle_pkg::TICKS_CLEAR
      && tick_cnt_reg == 8'h00) else $error("clear timer wrong");
  chk_clear_state: assert property (go_i && d_clear |=>
      ram_pointer_reg == 7'h00 && disp_shift_reg == 6'h00 && mode_reg.inc
      && mode_reg.autoshift == $past(mode_reg.autoshift))
      else $error("clear state wrong");
  chk_home_keep: assert property (go_i && d_home |=>
      ram_pointer_reg == 7'h00 && $stable(mode_reg))
      else $error("home changed mode");
  chk_data_step: assert property (go_w || rd_go |=>
      ram_pointer_reg == $past(ptr_step)) else $error("pointer step");
  chk_glyph_cursor: assert property (glyph_sel_reg |=>
      !cursor_underline_en && !cursor_blink_en)
      else $error("cursor shown in glyph");
  chk_no_shift: assert property (go_w &&
      (glyph_sel_reg || !mode_reg.autoshift) |=> $stable(disp_shift_reg))
      else $error("unexpected shift");
  chk_display_off: assert property (go_i && d_dctl && !ib[2]
      |-> ##[1:3] !lcd_drive_en && !bias_gen_en)
      else $error("display not off");
  chk_busy_block: assert property (wr_done && instruction_pending_flag
      |=> $stable(ram_pointer_reg) && $stable(mode_reg))
      else $error("busy write executed");
  chk_serial_width: assert property (go_i && d_fset &&
      serial_link_reg |=> mode_reg.bus_width_select)
      else $error("serial width");
  chk_holding_keep: assert property (go_w || (go_i &&
      (d_clear || d_home || d_shift)) |=> $stable(data_holding_register))
      else $error("holding changed");
  chk_gaddr_top: assert property (go_i && d_gaddr |=>
      ram_pointer_reg[6] == $past(ram_pointer_reg[6]))
      else $error("bit 6 loaded");

  cov_clear_done: cover property (go_i && d_clear ##[1:1000]
      !instruction_pending_flag);
  cov_data_read: cover property (rd_go);
  cov_nibble_write: cover property (!bus8 && wr_done);
  cov_line_wrap: cover property (go_i && d_shift && !ib[3]
      && ram_pointer_reg == cle_pkg::LAST_L1 && mode_reg.two_line);

endmodule : cle_instr_exec

// file: hw/cle_pkg.sv
// Contract
// - Clear fills text RAM with 20H, zeroes pointer and shift, sets increment
// - Clear lasts 165 oscillator ticks with busy set; blind hosts must wait
// - Return home zeroes pointer and shift, keeps RAM and entry mode
// - Each RAM data access steps pointer up or down per direction bit
// - Cursor underline and blink are suppressed while glyph RAM is selected
// - Auto-shift moves display on text RAM writes only, per direction
// - Display off grounds LCD outputs and generators within three ticks
// - Cursor-on shows five-dot underline on the eighth row
// - Blink alternates cursor character at oscillator rate over 52224
// - Cursor or display shift without RAM access; lines wrap after 40
// - Display shift keeps pointer; cursor shift steps it
// - Bus width set moves bytes, clear moves two upper nibbles
// - First 4-bit function set forces line, mux9, extended bits high
// - Function set over serial link always forces bus width to 1
// - Line bit picks 1x24 or 2x12; single-line mux9 overrides both
// - Extended bit selects basic or extended instruction decoding
// - Pointer is 7 bits shared; glyph address loads bits 5..0 only
// - Text address loads all seven pointer bits and selects text RAM
// - Status returns busy and pointer; busy blocks instruction execution
// - Write data stores to selected RAM; glyph keeps bits 4..0
// - Read data returns holding register, then steps and reloads it
// - Only address loads and data reads update the holding register
package cle_pkg;

  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0C;
  localparam logic [7:0] OFF_MODES = 8'h10;
  localparam logic [7:0] OFF_EXT = 8'h14;

  // ************************************************************
  // Timing and layout constants
  // ************************************************************
  localparam logic [7:0] TICKS_CLEAR = 8'hA5;
  localparam logic [7:0] TICKS_STD = 8'h03;
  localparam int unsigned BLINK_DIV_DFLT = 32'h0000CC00;
  localparam logic [7:0] BLANK_CODE = 8'h20;
  localparam logic [6:0] LAST_L1 = 7'h27;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LAST_L2 = 7'h4F;
  localparam logic [5:0] SHIFT_LAST = 6'h27;
  localparam logic [1:0] MUX_1X24 = 2'h0;
  localparam logic [1:0] MUX_2X12 = 2'h1;
  localparam logic [1:0] MUX_9 = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic inc;
    logic autoshift;
    logic disp_on;
    logic cursor_on;
    logic blink_on;
    logic bus_width_select;
    logic two_line;
    logic single_line_mux9;
    logic ext_set;
  } cle_mode_t;

  typedef struct packed {
    logic scr_mirror;
    logic col_mirror;
    logic row_mirror;
    logic icon_only_mode;
    logic icon_blink;
    logic direct_supply_mode;
    logic [1:0] temp_coef;
    logic [1:0] hv_stages;
    logic [5:0] vlcd_a;
    logic [5:0] vlcd_b;
  } cle_ext_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } cle_avs_req_t;

  typedef enum {CLE_IDLE, CLE_EXEC} cle_state_t;

  localparam cle_mode_t MODE_RST = 9'h108;
  localparam cle_ext_t EXT_RST = 22'h002000;

endpackage : cle_pkg

// file: verif/cle_host.sv
`timescale 1ns/1ps
// ************************************************************
// Host model: Avalon master driving the instruction executor
// ************************************************************
module cle_host (
  input wire logic clk,
  output cle_pkg::cle_avs_req_t avs,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial avs = '0;
  // Set by the bench while the device runs with half-width transfers
  logic nib = 1'b0;

  // One transfer, held until waitrequest is sampled low
  task automatic xfer(input logic rd, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs <= '{read: rd, write: !rd, address: a, writedata: d,
      byteenable: 4'hF};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    // Released data shows a changed pattern, not the old byte
    avs <= '{writedata: ~d, default: '0};
  endtask : xfer

  // Polls busy so no instruction is sent while one runs; in nibble
  // mode each status read is a pair, busy rides in the first half
  task automatic idle();
    logic [31:0] s;
    logic [31:0] lo;
    s = 32'h80;
    while (s[7] !== 1'b0) begin
      xfer(1'b1, cle_pkg::OFF_STATUS, 32'h0, s);
      if (nib) xfer(1'b1, cle_pkg::OFF_STATUS, 32'h0, lo);
    end
  endtask : idle
endmodule : cle_host

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic rst_n;
  cle_pkg::cle_avs_req_t avs;
  logic [31:0] rdata;
  logic [31:0] q;
  logic wreq;
  logic lcd_en, bias_en, ul_en, bl_en, bphase, p;
  logic [5:0] shpos;
  logic [1:0] mux;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  // ************************************************************
  // Design and host
  // ************************************************************
  // Short tick and blink divider keep the run brief
  cle_instr_exec #(.OSC_DIV(1), .BLINK_DIV(16)) u_cle_instr_exec (
    .clk(clk), .rst_n(rst_n), .avs(avs), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .lcd_drive_en(lcd_en),
    .bias_gen_en(bias_en), .cursor_underline_en(ul_en),
    .cursor_blink_en(bl_en), .blink_phase(bphase),
    .display_shift_pos(shpos), .mux_select(mux));
  cle_host host (.clk(clk), .avs(avs), .avs_readdata(rdata),
    .avs_waitrequest(wreq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic ins(input logic [7:0] b);
    host.xfer(1'b0, cle_pkg::OFF_INSTR, {24'h0, b}, q);
    host.idle();
  endtask : ins

  task automatic wd(input logic [7:0] b);
    host.xfer(1'b0, cle_pkg::OFF_DATA, {24'h0, b}, q);
    host.idle();
  endtask : wd

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b1, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic stop_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(cle_pkg::OFF_STATUS, 32'h80);
    chk({lcd_en, bias_en}, 2'b00);
    host.idle();
    rd(cle_pkg::OFF_MODES, 32'h108);
    rd(8'h1C, 32'h0);
    // Text writes step the pointer up
    ins(8'h85);
    wd(8'h41);
    wd(8'h42);
    rd(cle_pkg::OFF_STATUS, 32'h07);
    // Reads return holding, then step and reload
    ins(8'h85);
    rd(cle_pkg::OFF_DATA, 32'h41);
    host.idle();
    rd(cle_pkg::OFF_DATA, 32'h42);
    host.idle();
    rd(cle_pkg::OFF_STATUS, 32'h07);
    // A write must not touch the holding register
    ins(8'h90);
    wd(8'h55);
    rd(cle_pkg::OFF_DATA, 32'h20);
    host.idle();
    ins(8'h04);
    ins(8'h85);
    wd(8'h43);
    rd(cle_pkg::OFF_STATUS, 32'h04);
    // Display, cursor and blink on
    ins(8'h0F);
    chk({lcd_en, bias_en, ul_en, bl_en}, 4'hF);
    @(negedge clk);
    p = bphase;
    repeat (8) @(negedge clk);
    chk(bphase, {31'h0, ~p});
    // Glyph address keeps pointer bit 6 from the text address
    ins(8'hC5);
    ins(8'h42);
    rd(cle_pkg::OFF_STATUS, 32'h42);
    chk({ul_en, bl_en}, 2'b00);
    wd(8'hFF);
    ins(8'h42);
    rd(cle_pkg::OFF_DATA, 32'h1F);
    host.idle();
    // Display off must ground outputs within three ticks
    host.xfer(1'b0, cle_pkg::OFF_INSTR, 32'h08, q);
    repeat (3) @(posedge clk);
    #1 chk({lcd_en, bias_en}, 2'b00);
    host.idle();
    // Shifts: display moves keep pointer, cursor moves step it
    ins(8'h80);
    ins(8'h18);
    chk(shpos, 6'd1);
    rd(cle_pkg::OFF_STATUS, 32'h00);
    ins(8'h14);
    rd(cle_pkg::OFF_STATUS, 32'h01);
    ins(8'h1C);
    ins(8'h1C);
    chk(shpos, 6'd39);
    // Auto-shift moves on text writes, not reads
    ins(8'h07);
    ins(8'h80);
    wd(8'h31);
    chk(shpos, 6'd0);
    rd(cle_pkg::OFF_DATA, 32'h20);
    host.idle();
    chk(shpos, 6'd0);
    ins(8'h02);
    rd(cle_pkg::OFF_STATUS, 32'h00);
    rd(cle_pkg::OFF_MODES, 32'h188);
    // Clear from decrement mode, busy throughout
    ins(8'h05);
    host.xfer(1'b0, cle_pkg::OFF_INSTR, 32'h01, q);
    repeat (100) @(posedge clk);
    // Address load sent while busy must be dropped
    host.xfer(1'b0, cle_pkg::OFF_INSTR, 32'h85, q);
    rd(cle_pkg::OFF_STATUS, 32'h80);
    host.idle();
    rd(cle_pkg::OFF_MODES, 32'h188);
    ins(8'h85);
    rd(cle_pkg::OFF_DATA, 32'h20);
    host.idle();
    // Line and mux modes
    ins(8'h34);
    chk(mux, cle_pkg::MUX_2X12);
    ins(8'h36);
    chk(mux, cle_pkg::MUX_9);
    ins(8'h30);
    chk(mux, cle_pkg::MUX_1X24);
    ins(8'h31);
    rd(cle_pkg::OFF_MODES, 32'h189);
    ins(8'h0E);
    rd(cle_pkg::OFF_EXT, 32'h00062000);
    ins(8'h30);
    // Serial link forces full bus width
    host.xfer(1'b0, cle_pkg::OFF_CONFIG, 32'h1, q);
    ins(8'h20);
    rd(cle_pkg::OFF_MODES, 32'h188);
    host.xfer(1'b0, cle_pkg::OFF_CONFIG, 32'h0, q);
    // Nibble setup: floating low lines read high on the first set
    host.xfer(1'b0, cle_pkg::OFF_INSTR, 32'h2F, q);
    host.nib = 1'b1;
    host.idle();
    rd(cle_pkg::OFF_MODES, 32'h187);
    // Second set as two upper nibbles, then 30h the same way
    host.xfer(1'b0, cle_pkg::OFF_INSTR, 32'h20, q);
    host.xfer(1'b0, cle_pkg::OFF_INSTR, 32'h00, q);
    host.idle();
    rd(cle_pkg::OFF_MODES, 32'h180);
    host.xfer(1'b0, cle_pkg::OFF_INSTR, 32'h30, q);
    host.xfer(1'b0, cle_pkg::OFF_INSTR, 32'h00, q);
    repeat (8) @(posedge clk);
    rd(cle_pkg::OFF_MODES, 32'h188);
    stop_test();
  end
endmodule : testbench
